// [hdl/seq_loop_pkg.sv]
package seq_loop_pkg;
    // ****************
    // register map
    // ****************
    localparam logic [7:0] ADDR_MAIN_REPEAT = 8'h19;
    localparam logic [7:0] ADDR_OD_OFFSET = 8'h1a;
    localparam logic [7:0] ADDR_PS_OFFSET = 8'h1b;
    localparam logic [7:0] ADDR_SEQ_STATUS = 8'h30;
    localparam logic [7:0] RST_MAIN_REPEAT = 8'h00;
    localparam logic [7:0] RST_OD_OFFSET = 8'h00;
    localparam logic [7:0] RST_PS_OFFSET = 8'h00;
    // ****************
    // field layout
    // ****************
    localparam int REPEAT_LSB = 0;
    localparam int REPEAT_MSB = 2;
    localparam logic [2:0] REPEAT_ENDLESS = 3'h7;
    localparam int STAT_BUSY_BIT = 7;
    localparam int STAT_PASS_LSB = 3;
    localparam int STAT_SLOT_LSB = 0;
    localparam int SLOT_COUNT = 8;
    // ****************
    // sample classes
    // ****************
    typedef enum logic [1:0] {
        CLS_OTHER,
        CLS_OVERDRIVE,
        CLS_POS_SUSTAIN
    } sample_class_t;
endpackage

// [hdl/seq_loop_regs.sv]
`timescale 1ns/1ps
module seq_loop_regs (
    input wire logic clock, // 25 MHz
    input wire logic rst_b, // async reset
    input wire logic ce, // freezes all state when low
    input wire logic [7:0] addr, // register address
    input wire logic [7:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [7:0] rdata, // read data, cycle after rd
    input wire logic launch, // playback launch bit level
    input wire logic trigger_pin, // external trigger pin
    input wire logic [63:0] slot_ids, // eight 8-bit effect ids, slot 0 low
    input wire logic effect_done, // playback engine finished effect
    output logic effect_req, // one-cycle start of an effect
    output logic [7:0] effect_id, // id of effect requested
    output logic seq_busy, // sequencer running
    input wire logic seg_valid, // waveform sample strobe
    input wire logic signed [7:0] seg_level, // sample voltage
    input wire logic signed [7:0] wave_max, // highest sample of waveform
    input wire logic [15:0] seg_dur, // sample duration in ms
    input wire logic [7:0] effect_step_period, // step period in ms
    input wire logic open_loop, // open-loop drive mode
    output logic seg_out_valid, // adjusted sample strobe
    output logic [15:0] seg_dur_out, // adjusted duration in ms
    output logic [1:0] seg_class // sample class code
);
    // every check below runs on the one clock and is off while reset is low
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // ****************
    // slot unpacking
    // ****************
    localparam int SLOT_COUNT = seq_loop_pkg::SLOT_COUNT;
    logic [7:0] slot_id [SLOT_COUNT];
    genvar gi;
    generate
        for (gi = 0; gi < SLOT_COUNT; gi++) begin : g_slot
            assign slot_id[gi] = slot_ids[gi*8 +: 8];
        end
    endgenerate

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ****************
    // register file
    // ****************
    logic [7:0] repeat_ff, nxt_repeat;
    logic [7:0] od_off_ff, nxt_od_off;
    logic [7:0] ps_off_ff, nxt_ps_off;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [7:0] status;

    // writes store all bits; reserved bits of the repeat register read back
    always_comb begin
        nxt_repeat = repeat_ff;
        nxt_od_off = od_off_ff;
        nxt_ps_off = ps_off_ff;
        nxt_rdata = rdata_ff;
        if (wr && hit(addr, seq_loop_pkg::ADDR_MAIN_REPEAT)) nxt_repeat = wdata;
        if (wr && hit(addr, seq_loop_pkg::ADDR_OD_OFFSET)) nxt_od_off = wdata;
        if (wr && hit(addr, seq_loop_pkg::ADDR_PS_OFFSET)) nxt_ps_off = wdata;
        if (rd) begin
            if (hit(addr, seq_loop_pkg::ADDR_MAIN_REPEAT)) nxt_rdata = repeat_ff;
            else if (hit(addr, seq_loop_pkg::ADDR_OD_OFFSET)) nxt_rdata = od_off_ff;
            else if (hit(addr, seq_loop_pkg::ADDR_PS_OFFSET)) nxt_rdata = ps_off_ff;
            else if (hit(addr, seq_loop_pkg::ADDR_SEQ_STATUS)) nxt_rdata = status;
            else nxt_rdata = 8'h00; // unmapped reads zero
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            repeat_ff <= seq_loop_pkg::RST_MAIN_REPEAT;
            od_off_ff <= seq_loop_pkg::RST_OD_OFFSET;
            ps_off_ff <= seq_loop_pkg::RST_PS_OFFSET;
            rdata_ff <= 8'h00;
        end else if (ce) begin
            repeat_ff <= nxt_repeat;
            od_off_ff <= nxt_od_off;
            ps_off_ff <= nxt_ps_off;
            rdata_ff <= nxt_rdata;
        end
    end
    assign rdata = rdata_ff;

    // ****************
    // trigger synchroniser and launch edges
    // ****************
    logic trig_s1_ff, trig_s2_ff, trig_s3_ff, trig_lvl_ff, nxt_trig_lvl;
    logic launch_q_ff;
    logic trig_rise, launch_rise, launch_fall, stop_evt;

    // a change is accepted only once stages two and three agree
    always_comb begin
        nxt_trig_lvl = trig_lvl_ff;
        if (trig_s2_ff == trig_s3_ff) nxt_trig_lvl = trig_s3_ff;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            trig_s1_ff <= 1'b0;
            trig_s2_ff <= 1'b0;
            trig_s3_ff <= 1'b0;
            trig_lvl_ff <= 1'b0;
            launch_q_ff <= 1'b0;
        end else if (ce) begin
            trig_s1_ff <= trigger_pin;
            trig_s2_ff <= trig_s1_ff;
            trig_s3_ff <= trig_s2_ff;
            trig_lvl_ff <= nxt_trig_lvl;
            launch_q_ff <= launch;
        end
    end
    assign trig_rise = nxt_trig_lvl && !trig_lvl_ff;
    assign launch_rise = launch && !launch_q_ff;
    assign launch_fall = !launch && launch_q_ff;
    assign stop_evt = trig_rise || launch_fall;

    // ****************
    // sequencer
    // ****************
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_ISSUE,
        SEQ_WAIT
    } seq_state_t;
    seq_state_t state_ff, nxt_state;
    logic [2:0] slot_ff, nxt_slot;
    logic [2:0] pass_ff, nxt_pass;
    logic req_ff, nxt_req;
    logic [7:0] id_ff, nxt_id;
    logic last_slot, more_pass;
    logic [2:0] rep_cnt;

    assign rep_cnt = repeat_ff[seq_loop_pkg::REPEAT_MSB:seq_loop_pkg::REPEAT_LSB];
    // pass ends after slot seven or before a zero id
    assign last_slot = (slot_ff == 3'h7) || (slot_id[slot_ff + 3'h1] == 8'h00);
    // endless at seven, else count+1 passes in total
    assign more_pass = (rep_cnt == seq_loop_pkg::REPEAT_ENDLESS) || (pass_ff < rep_cnt);

    // trigger rise and launch-clear take priority over effect completion
    always_comb begin
        nxt_state = state_ff;
        nxt_slot = slot_ff;
        nxt_pass = pass_ff;
        nxt_req = 1'b0;
        nxt_id = id_ff;
        case (state_ff)
            SEQ_IDLE: begin
                if (launch_rise && slot_id[0] != 8'h00) begin
                    nxt_state = SEQ_ISSUE;
                    nxt_slot = 3'h0;
                    nxt_pass = 3'h0;
                end
            end
            SEQ_ISSUE: begin
                if (stop_evt) begin
                    nxt_state = SEQ_IDLE;
                end else begin
                    nxt_req = 1'b1;
                    nxt_id = slot_id[slot_ff];
                    nxt_state = SEQ_WAIT;
                end
            end
            SEQ_WAIT: begin
                if (stop_evt) begin
                    nxt_state = SEQ_IDLE;
                end else if (effect_done) begin
                    if (!last_slot) begin
                        nxt_slot = slot_ff + 3'h1;
                        nxt_state = SEQ_ISSUE;
                    end else if (more_pass) begin
                        // whole sequence again from slot zero
                        nxt_slot = 3'h0;
                        nxt_state = SEQ_ISSUE;
                        // endless mode saturates the counter for status only
                        if (pass_ff != 3'h7) nxt_pass = pass_ff + 3'h1;
                    end else begin
                        nxt_state = SEQ_IDLE;
                    end
                end
            end
            default: nxt_state = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= SEQ_IDLE;
            slot_ff <= 3'h0;
            pass_ff <= 3'h0;
            req_ff <= 1'b0;
            id_ff <= 8'h00;
        end else if (ce) begin
            state_ff <= nxt_state;
            slot_ff <= nxt_slot;
            pass_ff <= nxt_pass;
            req_ff <= nxt_req;
            id_ff <= nxt_id;
        end
    end
    assign effect_req = req_ff;
    assign effect_id = id_ff;
    assign seq_busy = (state_ff != SEQ_IDLE);

    // status packs busy, pass count and slot; unused bits read zero
    always_comb begin
        status = 8'h00;
        status[seq_loop_pkg::STAT_BUSY_BIT] = seq_busy;
        status[seq_loop_pkg::STAT_PASS_LSB +: 3] = pass_ff;
        status[seq_loop_pkg::STAT_SLOT_LSB +: 3] = slot_ff;
    end

    // ****************
    // sample time offsets
    // ****************
    logic out_v_ff, nxt_out_v;
    logic [15:0] dur_ff, nxt_dur;
    logic [1:0] cls_ff, nxt_cls;
    logic signed [17:0] adj, sum;
    logic signed [7:0] off;
    logic is_od, is_ps;

    // a positive sample at the waveform maximum is overdrive; other positive samples are sustain
    assign is_od = (seg_level == wave_max) && (seg_level > 8'sh00);
    assign is_ps = (seg_level > 8'sh00) && !is_od;
    // overdrive offset is ignored in closed loop
    assign off = (is_od && open_loop) ? $signed(od_off_ff) :
        (is_ps ? $signed(ps_off_ff) : 8'sh00);
    assign adj = 18'(off * $signed({1'b0, effect_step_period}));
    assign sum = $signed({2'b00, seg_dur}) + adj;

    always_comb begin
        nxt_out_v = seg_valid;
        nxt_dur = dur_ff;
        nxt_cls = cls_ff;
        if (seg_valid) begin
            if (sum < 18'sh0_0000) nxt_dur = 16'h0000;
            else if (sum > 18'sh0_ffff) nxt_dur = 16'hffff;
            else nxt_dur = sum[15:0];
            nxt_cls = is_od ? seq_loop_pkg::CLS_OVERDRIVE :
                (is_ps ? seq_loop_pkg::CLS_POS_SUSTAIN : seq_loop_pkg::CLS_OTHER);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            out_v_ff <= 1'b0;
            dur_ff <= 16'h0000;
            cls_ff <= 2'h0;
        end else if (ce) begin
            out_v_ff <= nxt_out_v;
            dur_ff <= nxt_dur;
            cls_ff <= nxt_cls;
        end
    end
    assign seg_out_valid = out_v_ff;
    assign seg_dur_out = dur_ff;
    assign seg_class = cls_ff;

    // ****************
    // checks
    // ****************
    // a pass ends on completion of its last slot with no stop pending
    sequence s_pass_end;
        ce && state_ff == SEQ_WAIT && effect_done && last_slot && !stop_evt;
    endsequence

    a_od_readback: assert property (
        ce && rd && addr == seq_loop_pkg::ADDR_OD_OFFSET |=> rdata == $past(od_off_ff))
        else $error("offset readback wrong");
    a_single_pass: assert property (
        s_pass_end and rep_cnt == 3'h0 |=> state_ff == SEQ_IDLE)
        else $error("extra pass played");
    a_endless_loop: assert property (
        s_pass_end and rep_cnt == 3'h7 |=> state_ff == SEQ_ISSUE && slot_ff == 3'h0)
        else $error("endless stopped");
    a_replay_whole: assert property (
        s_pass_end and pass_ff < rep_cnt
        |=> (state_ff == SEQ_ISSUE && slot_ff == 3'h0)
        and (ce && !stop_evt |=> effect_id == slot_id[0]))
        else $error("bad replay");
    a_zero_slot: assert property (
        state_ff == SEQ_ISSUE |-> slot_id[slot_ff] != 8'h00)
        else $error("zero id issued");
    a_slot_step: assert property (
        ce && state_ff == SEQ_WAIT && effect_done && !last_slot && !stop_evt
        |=> slot_ff == $past(slot_ff) + 3'h1) else $error("slot skip");
    a_stop_event: assert property (
        ce && stop_evt && seq_busy |=> !seq_busy)
        else $error("stop ignored");
    a_closed_loop: assert property (
        ce && seg_valid && !open_loop && is_od |=> seg_dur_out == $past(seg_dur))
        else $error("od offset in closed loop");
    a_clamp_zero: assert property (
        ce && seg_valid && sum < 18'sh0_0000 |=> seg_dur_out == 16'h0000)
        else $error("no clamp");
    a_class_od: assert property (
        ce && seg_valid && is_od |=> seg_class == seq_loop_pkg::CLS_OVERDRIVE)
        else $error("od class");
    a_class_ps: assert property (
        ce && seg_valid && seg_level > 8'sh00 && seg_level != wave_max
        |=> seg_class == seq_loop_pkg::CLS_POS_SUSTAIN) else $error("sustain class");
    // in range the output must be the full product, not merely differ from the input
    a_od_scale: assert property (
        ce && seg_valid && is_od && open_loop && sum >= 18'sh0_0000 && sum <= 18'sh0_ffff
        |=> $signed({2'b00, seg_dur_out}) == $signed({2'b00, $past(seg_dur)})
        + 18'($signed($past(od_off_ff)) * $signed({1'b0, $past(effect_step_period)})))
        else $error("od scale");
endmodule // seq_loop_regs

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb;
    // ****************
    // bench signals
    // ****************
    logic clock = 1'h0, rst_b = 1'h0, ce = 1'h1, wr = 1'h0, rd = 1'h0, rd_q = 1'h0;
    logic launch = 1'h0, trigger_pin = 1'h0, effect_done = 1'h0, seg_valid = 1'h0;
    logic open_loop = 1'h0, effect_req, seq_busy, seg_out_valid;
    logic [7:0] addr = 8'h00, wdata = 8'h00, effect_step_period = 8'h00, rdata, effect_id;
    logic signed [7:0] seg_level = 8'sh00, wave_max = 8'sh00, od_v = 8'sh00, ps_v = 8'sh00;
    logic [15:0] seg_dur = 16'h0000, seg_dur_out;
    logic [63:0] slot_ids = 64'h0000_0000_0000_0000;
    logic [1:0] seg_class;
    logic [7:0] rq[$], eq[$];
    logic [17:0] sq[$];
    int mismatches = 0, checked = 0, cycles = 0, seed = 43378;

    seq_loop_regs dut (.clock(clock), .rst_b(rst_b), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .launch(launch), .trigger_pin(trigger_pin),
        .slot_ids(slot_ids), .effect_done(effect_done), .effect_req(effect_req),
        .effect_id(effect_id), .seq_busy(seq_busy), .seg_valid(seg_valid),
        .seg_level(seg_level), .wave_max(wave_max), .seg_dur(seg_dur),
        .effect_step_period(effect_step_period), .open_loop(open_loop),
        .seg_out_valid(seg_out_valid), .seg_dur_out(seg_dur_out), .seg_class(seg_class));

    // 25 MHz clock
    always #20 clock = ~clock;

    // ****************
    // compare and report
    // ****************
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask

    task automatic cmp_seg(input logic [17:0] got, input logic [17:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // watcher: an empty queue is compared against a value no output can take
    always @(posedge clock) begin
        rd_q <= rd;
        if (rd_q) begin
            cmp_byte(rdata, rq.size() > 0 ? rq.pop_front() : 8'hxx);
        end
        if (effect_req) begin
            cmp_byte(effect_id, eq.size() > 0 ? eq.pop_front() : 8'hxx);
        end
        if (seg_out_valid) begin
            cmp_seg({seg_class, seg_dur_out}, sq.size() > 0 ? sq.pop_front() : 18'hx);
        end
    end

    // hang guard, well above the thousand or so cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    // ****************
    // drivers
    // ****************
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clock);
        wr <= 1'h0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rd <= 1'h1;
        rq.push_back(exp);
        @(posedge clock);
        rd <= 1'h0;
    endtask

    task automatic set_offs(input logic [7:0] od, input logic [7:0] ps);
        od_v = od;
        ps_v = ps;
        wr_reg(seq_loop_pkg::ADDR_OD_OFFSET, od);
        wr_reg(seq_loop_pkg::ADDR_PS_OFFSET, ps);
    endtask

    // one sample per call, valid stays high so calls run back to back
    task automatic seg(input logic signed [7:0] lvl, input logic signed [7:0] mx,
                       input logic [15:0] dur, input logic [7:0] per, input logic ol);
        logic [1:0] cls;
        int off;
        int d;
        cls = (lvl > 0) ? ((lvl == mx) ? seq_loop_pkg::CLS_OVERDRIVE
                                       : seq_loop_pkg::CLS_POS_SUSTAIN) : 2'h0;
        off = (cls == 2'h1 && ol) ? int'(od_v) : (cls == 2'h2) ? int'(ps_v) : 0;
        d = int'(dur) + off * int'(per);
        d = (d < 0) ? 0 : (d > 65535) ? 65535 : d;
        @(posedge clock);
        seg_level <= lvl;
        wave_max <= mx;
        seg_dur <= dur;
        effect_step_period <= per;
        open_loop <= ol;
        seg_valid <= 1'h1;
        sq.push_back({cls, d[15:0]});
    endtask

    // a zero in slot n ends the pass even with nonzero ids after it
    task automatic run_seq(input logic [2:0] rep, input int n, input logic by_trig);
        logic [63:0] ids;
        int total;
        for (int i = 0; i < 8; i++) ids[i*8 +: 8] = (i == n) ? 8'h00 : 8'($random(seed)) | 8'h01;
        total = (n == 0) ? 0 : (rep == 3'h7) ? 2 * n + 1 : n * (rep + 1);
        for (int k = 0; k < total; k++) eq.push_back(ids[(k % n)*8 +: 8]);
        slot_ids <= ids;
        wr_reg(seq_loop_pkg::ADDR_MAIN_REPEAT, {5'h00, rep});
        @(posedge clock);
        launch <= 1'h1;
        for (int k = 0; k < total; k++) begin
            for (int w = 0; w < 30 && effect_req !== 1'h1; w++) @(posedge clock);
            if (k == total - 1 && rep == 3'h7) begin
                if (by_trig) trigger_pin <= 1'h1;
                else launch <= 1'h0;
            end else begin
                effect_done <= 1'h1;
                @(posedge clock);
                effect_done <= 1'h0;
            end
            @(posedge clock);
        end
        for (int w = 0; w < 12 && seq_busy !== 1'h0; w++) @(posedge clock);
        repeat (4) @(posedge clock);
        cmp_byte({7'h00, seq_busy}, 8'h00);
        cmp_byte(8'(eq.size()), 8'h00);
        launch <= 1'h0;
        trigger_pin <= 1'h0;
        repeat (6) @(posedge clock);
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        logic [7:0] v;
        repeat (16) @(posedge clock);
        rst_b <= 1'h1;
        rd_reg(seq_loop_pkg::ADDR_MAIN_REPEAT, seq_loop_pkg::RST_MAIN_REPEAT);
        rd_reg(seq_loop_pkg::ADDR_OD_OFFSET, seq_loop_pkg::RST_OD_OFFSET);
        rd_reg(seq_loop_pkg::ADDR_PS_OFFSET, seq_loop_pkg::RST_PS_OFFSET);
        rd_reg(seq_loop_pkg::ADDR_SEQ_STATUS, 8'h00);
        for (int i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            wr_reg(8'h19 + 8'(i % 3), v);
            wr_reg(8'h1c, ~v);
            rd_reg(8'h19 + 8'(i % 3), v);
        end
        rd_reg(8'h55, 8'h00);
        // a write while the clock enable is low must leave the register alone
        wr_reg(seq_loop_pkg::ADDR_OD_OFFSET, 8'h3c);
        ce <= 1'h0;
        wr_reg(seq_loop_pkg::ADDR_OD_OFFSET, 8'hc3);
        ce <= 1'h1;
        rd_reg(seq_loop_pkg::ADDR_OD_OFFSET, 8'h3c);
        $display("register test done");
        set_offs(8'hfd, 8'h07);
        seg(8'sd100, 8'sd100, 16'h0032, 8'h05, 1'h1);
        seg(8'sd100, 8'sd100, 16'h0032, 8'h05, 1'h0);
        seg(8'sd40, 8'sd100, 16'h0032, 8'h05, 1'h1);
        seg(-8'sd20, 8'sd100, 16'h0032, 8'h05, 1'h1);
        seg(8'sd0, 8'sd0, 16'h0032, 8'h05, 1'h1);
        @(posedge clock);
        seg_valid <= 1'h0;
        set_offs(8'h80, 8'h80);
        seg(8'sd9, 8'sd9, 16'h0100, 8'hff, 1'h1);
        seg(8'sd3, 8'sd9, 16'h0100, 8'hff, 1'h1);
        @(posedge clock);
        seg_valid <= 1'h0;
        for (int b = 0; b < 4; b++) begin
            set_offs(8'($random(seed)), 8'($random(seed)));
            // odd samples sit on the waveform maximum to reach the overdrive class
            for (int i = 0; i < 10; i++) begin
                v = 8'($random(seed)) & 8'h7f;
                seg((i % 2) ? v : 8'($random(seed)), v,
                    16'($random(seed)), 8'($random(seed)), 1'($random(seed)));
            end
            @(posedge clock);
            seg_valid <= 1'h0;
        end
        repeat (4) @(posedge clock);
        $display("offset test done");
        for (int r = 0; r < 7; r++) run_seq(3'(r), r + 2, 1'h0);
        run_seq(3'h0, 1, 1'h0);
        run_seq(3'h2, 0, 1'h0);
        run_seq(3'h7, 8, 1'h0);
        run_seq(3'h7, 3, 1'h1);
        $display("sequencer test done");
        final_report();
    end
endmodule // tb
